/* File: bench/spt_line_model.sv */
// Behavioural model of the presses, their done switches and the line drive.
`timescale 1ns/100ps
`default_nettype none
module spt_line_model
    import spt_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        cut_i,
    input  wire logic        hole_i,
    input  wire logic        fwd_i,
    input  var  int          dly_i,
    output logic             cut_done_o,
    output logic             hole_done_o,
    output logic [POS_W-1:0] pos_o
);
    int cut_n;
    int hole_n;
    // ************
    // Presses and line
    // ************
    // Each press counts its stroke; the line moves one count a cycle while driven forward.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cut_n  <= 0;
            hole_n <= 0;
            pos_o  <= '0;
        end else begin
            cut_n  <= cut_i ? cut_n + 1 : 0;
            hole_n <= hole_i ? hole_n + 1 : 0;
            pos_o  <= fwd_i ? pos_o + 1'b1 : pos_o;
        end
    end
    // A done switch closes after the stroke delay; a zero delay leaves it open.
    assign cut_done_o  = dly_i != 0 && cut_n >= dly_i;
    assign hole_done_o = dly_i != 0 && hole_n >= dly_i;
endmodule
`default_nettype wire

/* File: bench/spt_top_props.sv */
// Assertion checker bound to the shear and punch output timing block.
`timescale 1ns/100ps
`default_nettype none
module spt_top_props
    import spt_pkg::*;
#(
    parameter int PARAM_COUNT = 8
) (
    input wire logic               clk_i,
    input wire logic               reset_i,
    input wire logic               cycle_sw_i,
    input wire logic               cut_done_i,
    input wire logic [TIME_W-1:0]  cut_hold_time_i,
    input wire logic               hole_done_i,
    input wire logic               jog_fwd_i,
    input wire logic               jog_rev_i,
    input wire logic               two_speed_i,
    input wire logic               flying_die_i,
    input wire logic               boost_en_i,
    input wire logic               cal_start_i,
    input wire logic               manual_cal_i,
    input wire logic               enter_key_i,
    input wire logic               setup_key_i,
    input wire logic               cut_o,
    input wire logic               hole_o,
    input wire logic               boost_o,
    input wire logic               slow_o,
    input wire logic               fast_o,
    input wire logic [2:0]         cal_state_o,
    input wire logic [LEN_W-1:0]   cal_len_o,
    input wire logic               cal_calc_o,
    input wire logic [PARAM_W-1:0] param_idx_o
);
    // ************
    // Port relations
    // ************
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // Press outputs are quiet after reset and follow their switches.
    rst_quiet_a: assert property ($fell(reset_i) |-> !cut_o && !hole_o && !boost_o)
        else $error("press output high after reset");
    cut_start_a: assert property ($rose(cycle_sw_i) && !cut_o && !cut_done_i
        && cut_hold_time_i != '0 |-> ##[3:5] cut_o) else $error("cut did not start");
    cut_done_a: assert property ($rose(cut_done_i) && cut_o |-> ##[1:5] !cut_o)
        else $error("cut ignored its done switch");
    hole_done_a: assert property ($rose(hole_done_i) && hole_o |-> ##[1:5] !hole_o)
        else $error("punch ignored its done switch");
    // Jogging stays slow; calibration and parameter stepping keep their order.
    jog_slow_a: assert property ((two_speed_i && (jog_fwd_i || jog_rev_i))[*5]
        |-> slow_o && !fast_o) else $error("jog not at slow speed");
    cal_default_a: assert property (cal_start_i && cal_state_o == 3'h0
        |=> cal_state_o == 3'h1 && cal_len_o == 16'h0078) else $error("bad default length");
    cal_order_a: assert property (cal_state_o != $past(cal_state_o) |-> cal_state_o <= 3'h1
        || cal_state_o == $past(cal_state_o) + 3'h1)
        else $error("calibration step out of order");
    cal_calc_a: assert property (cal_calc_o |-> cal_state_o == 3'h6 ##1 cal_state_o == 3'h0)
        else $error("calculation pulse misplaced");
    param_step_a: assert property (manual_cal_i && (enter_key_i || setup_key_i)
        |=> param_idx_o == ($past(param_idx_o) + ($past(enter_key_i) ? 1 : PARAM_COUNT - 1))
        % PARAM_COUNT) else $error("parameter index stepped wrongly");
    boost_cfg_a: assert property ($rose(boost_o)
        |-> $past(flying_die_i) && $past(boost_en_i)) else $error("boost without flying die");
endmodule

bind spt_top spt_top_props #(.PARAM_COUNT(PARAM_COUNT)) u_props (.*);
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking testbench of the shear and punch output timing block.
`timescale 1ns/100ps
`default_nettype none
module tb
    import spt_pkg::*;
;
    logic clk_i, reset_i, cycle_sw_i, cut_done_i, manual_hole_i, hole_done_i, jog_fwd_i;
    logic jog_rev_i, run_sw_i, two_speed_i, fast_req_i, flying_die_i, boost_en_i, cut_arm_i;
    logic hole_arm_i, cal_start_i, cal_len_valid_i, two_parts_i, meas_valid_i, manual_cal_i;
    logic enter_key_i, setup_key_i, cut_o, hole_o, boost_o, fwd_o, rev_o, slow_o, fast_o;
    logic               cal_calc_o;
    logic [POS_W-1:0]   position_i, cut_target_i, hole_target_i;
    logic [TIME_W-1:0]  cut_hold_time_i, hole_hold_time_i, push_hold_time_i;
    logic [TIME_W-1:0]  cut_lead_i, hole_lead_i, push_lead_i;
    logic [LEN_W-1:0]   cal_len_i, cal_len_o;
    logic [2:0]         cal_state_o;
    logic [PARAM_W-1:0] param_idx_o;
    logic [15:0]        seed;
    int                 checks, num_errors, done_dly, exp_idx;

    spt_top #(.PARAM_COUNT(8)) i_dut (.*);
    spt_line_model i_line (.clk_i(clk_i), .reset_i(reset_i), .cut_i(cut_o), .hole_i(hole_o),
        .fwd_i(fwd_o), .dly_i(done_dly), .cut_done_o(cut_done_i), .hole_done_o(hole_done_i),
        .pos_o(position_i));

    // ************
    // Helpers
    // ************
    // The clock toggles every half period.
    always #50 clk_i = ~clk_i;

    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic bit near(int v, int c);
        return v >= c - 3 && v <= c + 1;
    endfunction

    // Inputs set by the test change a fixed delay after the rising edge; the line model's change on it.
    task automatic tick(int n = 1);
        repeat (n) begin
            @(posedge clk_i);
            #10;
        end
    endtask

    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask

    task automatic wait_out(bit hole, logic v, output int n);
        n = 0;
        while ((hole ? hole_o : cut_o) !== v && n < 5000) begin
            tick();
            n++;
        end
    endtask

    // One manual press cycle, ended by the done switch or else by the hold time.
    task automatic press(bit hole, int dly, int hold);
        int n, w;
        done_dly = dly;
        {cut_hold_time_i, hole_hold_time_i} = {2{16'(hold)}};
        {manual_hole_i, cycle_sw_i} = hole ? 2'b10 : 2'b01;
        wait_out(hole, 1'b1, n);
        chk(n >= 3 && n <= 5, 1);
        {cycle_sw_i, manual_hole_i} = '0;
        wait_out(hole, 1'b0, w);
        chk(dly ? (w > dly && w <= dly + 5)
            : (w > (hold - 1) * 1000 && w <= hold * 1000 + 2), 1);
        tick(3);
    endtask

    // Automatic calibration from start to the calculation pulse.
    task automatic cal(int len, bit two);
        two_parts_i = two;
        pulse(cal_start_i);
        chk(cal_len_o, 16'h0078);
        cal_len_i = 16'(len);
        pulse(cal_len_valid_i);
        chk(cal_len_o, len ? len : 16'h0078);
        chk(cal_state_o, 3'h2);
        press(0, 3, 2);
        chk(cal_state_o, 3'h3);
        run_sw_i = 1'b1;
        tick(5);
        run_sw_i = 1'b0;
        chk(cal_state_o, 3'h4);
        repeat (two + 1) press(0, 3, 2);
        chk(cal_state_o, 3'h5);
        repeat (two + 1) begin
            chk(cal_calc_o, 1'b0);
            tick();
            pulse(meas_valid_i);
        end
        chk(cal_calc_o, 1'b1);
        tick();
        chk(cal_state_o, 3'h0);
    endtask

    // Armed cut, punch and boost on a moving line, judged by distance to target.
    task automatic auto(bit fly, int lead, int push);
        int rem, crem, hrem, brem, cr = -1, bf = -1;
        bit hs = 0, bs = 0;
        flying_die_i = fly;
        boost_en_i = 1'b1;
        cut_lead_i = 16'(lead);
        hole_lead_i = 16'h0001;
        push_lead_i = 16'(push);
        {cut_hold_time_i, hole_hold_time_i, push_hold_time_i} = {3{16'h0001}};
        done_dly = 0;
        run_sw_i = 1'b1;
        tick(3000);
        cut_target_i = position_i + 32'h00001F40;
        hole_target_i = cut_target_i;
        {cut_arm_i, hole_arm_i} = 2'b11;
        tick();
        {cut_arm_i, hole_arm_i} = 2'b00;
        for (int n = 0; n < 12000; n++) begin
            rem = int'(cut_target_i - position_i);
            if (cut_o === 1'b1 && cr < 0) begin
                cr = n;
                crem = rem;
            end
            if (hole_o === 1'b1 && !hs) begin
                hs = 1;
                hrem = rem;
            end
            if (boost_o === 1'b1 && !bs) begin
                bs = 1;
                brem = rem;
            end
            if (bs && boost_o === 1'b0 && bf < 0) bf = n;
            tick();
        end
        run_sw_i = 1'b0;
        chk(cr >= 0 && near(crem, lead * fly * 1000), 1);
        chk(hs && near(hrem, fly * 1000), 1);
        chk(fly ? near(brem, (lead + push) * 1000) : !bs, 1);
        chk(!fly || (bf - cr >= (lead + 1) * 1000 && bf - cr <= (lead + 2) * 1000 + 3), 1);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ************
    // Test sequence
    // ************
    // All inputs start low; reset is held for four cycles.
    initial begin
        clk_i = 1'b0;
        reset_i = 1'b1;
        {cycle_sw_i, manual_hole_i, jog_fwd_i, jog_rev_i, run_sw_i, two_speed_i} = '0;
        {fast_req_i, flying_die_i, boost_en_i, cut_arm_i, hole_arm_i, cal_start_i} = '0;
        {cal_len_valid_i, two_parts_i, meas_valid_i, manual_cal_i, enter_key_i, setup_key_i} = '0;
        {cut_target_i, hole_target_i, cal_len_i, cut_lead_i, hole_lead_i, push_lead_i} = '0;
        {cut_hold_time_i, hole_hold_time_i, push_hold_time_i} = '0;
        {checks, num_errors, done_dly, exp_idx} = '0;
        seed = 16'h653E;
        tick(4);
        reset_i = 1'b0;
        tick(2);
        press(0, 3, 2);
        press(1, 3, 2);
        press(0, 0, 2);
        press(1, 0, 1);
        cut_hold_time_i = '0;
        cycle_sw_i = 1'b1;
        tick(8);
        chk(cut_o, 1'b0);
        cycle_sw_i = 1'b0;
        $display("Test manual presses ended");
        for (int k = 0; k < 32; k++) begin
            {two_speed_i, fast_req_i, run_sw_i, jog_rev_i, jog_fwd_i} = 5'(k);
            tick(6);
            chk({fwd_o, rev_o, slow_o, fast_o}, {k[0] | (k[2] & !k[1]), k[1] & !k[0],
                k[4] & (k[0] | k[1] | (k[2] & !k[3])), k[4] & k[3] & k[2] & !(k[0] | k[1])});
        end
        {two_speed_i, fast_req_i, run_sw_i, jog_rev_i, jog_fwd_i} = '0;
        $display("Test motion outputs ended");
        cal(0, 1);
        cal(200, 0);
        $display("Test calibration ended");
        manual_cal_i = 1'b1;
        repeat (40) begin
            seed = lfsr(seed);
            {setup_key_i, enter_key_i} = seed[1:0];
            tick();
            if (enter_key_i) exp_idx = (exp_idx + 1) % 8;
            else if (setup_key_i) exp_idx = (exp_idx + 7) % 8;
            chk(param_idx_o, exp_idx);
            {setup_key_i, enter_key_i} = 2'b00;
            tick();
        end
        manual_cal_i = 1'b0;
        $display("Test parameter stepping ended");
        auto(1, 2, 1);
        auto(0, 2, 1);
        $display("Test lead times ended");
        finish_test();
    end

    // Watchdog cuts a hung run short.
    initial begin
        #10_000_000;
        num_errors++;
        $display("MISMATCH at %0t: run timed out", $time);
        finish_test();
    end
endmodule
`default_nettype wire

/* File: src/spt_dwell.sv */
// Dwell timer that holds one press output for a count of ticks.
`timescale 1ns/100ps
`default_nettype none
module spt_dwell
    import spt_pkg::*;
#(
    parameter int W = TIME_W
) (
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic         start_i,
    input  wire logic         stop_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] len_i,
    output logic              active_o
);

    typedef struct packed {
        logic         active;
        logic [W-1:0] count;
    } spt_dwell_t;

    spt_dwell_t state_reg;
    spt_dwell_t state_next;

    // ************
    // Next state
    // ************

    // A start loads the length; a stop or an expired count ends the dwell.
    always_comb begin
        state_next = state_reg;
        if (start_i) begin
            state_next.active = (len_i != '0);
            state_next.count  = len_i;
        end else if (state_reg.active) begin
            if (stop_i) begin
                state_next.active = 1'b0;
            end else if (tick_i) begin
                state_next.count = state_reg.count - W'(1);
                if (state_reg.count <= W'(1)) begin
                    state_next.active = 1'b0;
                end
            end
        end
    end

    // State register.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign active_o = state_reg.active;

endmodule
`default_nettype wire

/* File: src/spt_pkg.sv */
// Shared constants and types of the shear and punch output timing block.
package spt_pkg;

    // ************
    // Clock and time base
    // ************
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS       = 100000;
    localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W        = 10;

    // ************
    // Time settings, counted in 0.1 ms ticks
    // ************
    localparam int TIME_W        = 16;
    localparam int LEAD_MAX_MS10 = 5000;
    localparam logic [TIME_W-1:0] LEAD_MAX = TIME_W'(LEAD_MAX_MS10);

    // ************
    // Positions, speed and calibration
    // ************
    localparam int POS_W   = 32;
    localparam int SPD_W   = 16;
    localparam int LEN_W   = 16;
    localparam logic [LEN_W-1:0] CAL_LEN_DEFAULT = 16'h0078;
    localparam int PARAM_W = 4;

    // ************
    // Automatic calibration sequence
    // ************
    typedef enum logic [2:0] {
        CAL_IDLE  = 3'b000,
        CAL_LEN   = 3'b001,
        CAL_TRIM  = 3'b010,
        CAL_RUN   = 3'b011,
        CAL_PARTS = 3'b100,
        CAL_MEAS  = 3'b101,
        CAL_CALC  = 3'b110
    } spt_cal_t;

endpackage

/* File: src/spt_top.sv */
// Cut, punch and die boost output sequencing with lead times and calibration.
//
// What this block does
// - The cycle switch starts cut; the first of its hold time and cut-done ends it.
// - Manual hole starts punch; the first of its hold time and hole-done ends it.
// - On two-speed lines a jog either way runs slow, never fast.
// - Auto calibration offers a part length of 120 inches unless one is entered.
// - Calibration: length, trim cut, run, one or two parts, then measured lengths.
// - In manual calibration enter steps to the next parameter and setup back one.
// - Cut lead time acts only on flying-die lines and is at most 0.5000 seconds.
// - A cut lead time moves the whole cut output, start and end, earlier by that time.
// - On flying-die lines boost starts the push lead time ahead of the coincidence point.
// - With cut lead and boost both used, boost starts ahead of the shifted cut start.
// - Boost lasts the push hold time past the unshifted end of the cut hold time.
// - Punch lead time acts only on flying-die lines and is at most 0.5000 seconds.
`timescale 1ns/100ps
`default_nettype none
module spt_top
    import spt_pkg::*;
#(
    parameter int PARAM_COUNT = 8
) (
    input  wire logic               clk_i,
    input  wire logic               reset_i,
    input  wire logic               cycle_sw_i,
    input  wire logic               cut_done_i,
    input  wire logic               manual_hole_i,
    input  wire logic               hole_done_i,
    input  wire logic               jog_fwd_i,
    input  wire logic               jog_rev_i,
    input  wire logic               run_sw_i,
    input  wire logic               two_speed_i,
    input  wire logic               fast_req_i,
    input  wire logic               flying_die_i,
    input  wire logic               boost_en_i,
    input  wire logic [POS_W-1:0]   position_i,
    input  wire logic [POS_W-1:0]   cut_target_i,
    input  wire logic               cut_arm_i,
    input  wire logic [POS_W-1:0]   hole_target_i,
    input  wire logic               hole_arm_i,
    input  wire logic [TIME_W-1:0]  cut_hold_time_i,
    input  wire logic [TIME_W-1:0]  hole_hold_time_i,
    input  wire logic [TIME_W-1:0]  push_hold_time_i,
    input  wire logic [TIME_W-1:0]  cut_lead_i,
    input  wire logic [TIME_W-1:0]  hole_lead_i,
    input  wire logic [TIME_W-1:0]  push_lead_i,
    input  wire logic               cal_start_i,
    input  wire logic               cal_len_valid_i,
    input  wire logic [LEN_W-1:0]   cal_len_i,
    input  wire logic               two_parts_i,
    input  wire logic               meas_valid_i,
    input  wire logic               manual_cal_i,
    input  wire logic               enter_key_i,
    input  wire logic               setup_key_i,
    output logic                    cut_o,
    output logic                    hole_o,
    output logic                    boost_o,
    output logic                    fwd_o,
    output logic                    rev_o,
    output logic                    slow_o,
    output logic                    fast_o,
    output logic [2:0]              cal_state_o,
    output logic [LEN_W-1:0]        cal_len_o,
    output logic                    cal_calc_o,
    output logic [PARAM_W-1:0]      param_idx_o
);

    // ************
    // State
    // ************

    typedef struct packed {
        logic [6:0]          sync1;
        logic [6:0]          sync2;
        logic                cycle_q;
        logic                hole_q;
        logic [TICK_W-1:0]   tick_cnt;
        logic [POS_W-1:0]    last_pos;
        logic [SPD_W-1:0]    speed;
        logic                cut_armed;
        logic                boost_armed;
        logic                hole_armed;
        logic                boost;
        logic                tail_q;
        logic                fwd;
        logic                rev;
        logic                slow;
        logic                fast;
        spt_cal_t            cal;
        logic [LEN_W-1:0]    cal_len;
        logic                parts_left;
        logic                meas_left;
        logic                calc;
        logic [PARAM_W-1:0]  param_idx;
    } spt_state_t;

    spt_state_t state_reg;
    spt_state_t state_next;

    // Synchronised pin levels, stage two only.
    logic cycle_s;
    logic cut_done_s;
    logic man_hole_s;
    logic hole_done_s;
    logic jog_fwd_s;
    logic jog_rev_s;
    logic run_s;
    assign {run_s, jog_rev_s, jog_fwd_s, hole_done_s, man_hole_s, cut_done_s, cycle_s} =
        state_reg.sync2;

    // ************
    // Lead times and coincidence
    // ************

    // Cut and punch lead settings are clamped; all lead settings are forced to zero off flying-die lines.
    logic [TIME_W-1:0] cut_lead_eff;
    logic [TIME_W-1:0] hole_lead_eff;
    logic [TIME_W-1:0] push_lead_eff;
    logic [TIME_W-1:0] boost_lead;
    always_comb begin
        cut_lead_eff  = '0;
        hole_lead_eff = '0;
        push_lead_eff = '0;
        if (flying_die_i) begin
            cut_lead_eff  = (cut_lead_i > LEAD_MAX) ? LEAD_MAX : cut_lead_i;
            hole_lead_eff = (hole_lead_i > LEAD_MAX) ? LEAD_MAX : hole_lead_i;
            push_lead_eff = boost_en_i ? push_lead_i : '0;
        end
        boost_lead = cut_lead_eff + push_lead_eff;
    end

    // Remaining distance to each target against the distance covered in the lead time.
    logic signed [POS_W-1:0] cut_rem;
    logic signed [POS_W-1:0] hole_rem;
    logic [POS_W-1:0]        cut_dist;
    logic [POS_W-1:0]        hole_dist;
    logic [POS_W-1:0]        boost_dist;
    assign cut_rem    = $signed(cut_target_i - position_i);
    assign hole_rem   = $signed(hole_target_i - position_i);
    assign cut_dist   = POS_W'(state_reg.speed * cut_lead_eff);
    assign hole_dist  = POS_W'(state_reg.speed * hole_lead_eff);
    assign boost_dist = POS_W'(state_reg.speed * boost_lead);

    logic cut_fire;
    logic hole_fire;
    logic boost_fire;
    assign cut_fire   = state_reg.cut_armed && (cut_rem <= $signed(cut_dist));
    assign hole_fire  = state_reg.hole_armed && (hole_rem <= $signed(hole_dist));
    assign boost_fire = state_reg.boost_armed && boost_en_i && flying_die_i &&
                        (cut_rem <= $signed(boost_dist));

    // ************
    // Dwell timers
    // ************

    logic tick;
    logic cycle_edge;
    logic hole_edge;
    logic cut_start;
    logic hole_start;
    logic cut_active;
    logic hole_active;
    logic tail_active;
    logic [TIME_W-1:0] tail_len;
    assign tick       = (state_reg.tick_cnt == TICK_W'(TICK_CYCLES - 1));
    assign cycle_edge = cycle_s && !state_reg.cycle_q;
    assign hole_edge  = man_hole_s && !state_reg.hole_q;
    assign cut_start  = !cut_active && (cycle_edge || cut_fire);
    assign hole_start = !hole_active && (hole_edge || hole_fire);
    // Tail runs from the shifted cut start to the unshifted hold end plus push hold.
    assign tail_len   = cut_lead_eff + cut_hold_time_i + push_hold_time_i;

    // Cut output: hold time or cut-done switch, whichever first.
    spt_dwell #(.W(TIME_W)) u_cut (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .start_i  (cut_start),
        .stop_i   (cut_done_s),
        .tick_i   (tick),
        .len_i    (cut_hold_time_i),
        .active_o (cut_active)
    );

    // Punch output: hold time or hole-done switch, whichever first.
    spt_dwell #(.W(TIME_W)) u_hole (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .start_i  (hole_start),
        .stop_i   (hole_done_s),
        .tick_i   (tick),
        .len_i    (hole_hold_time_i),
        .active_o (hole_active)
    );

    // Boost trailing timer.
    spt_dwell #(.W(TIME_W)) u_tail (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .start_i  (cut_start),
        .stop_i   (1'b0),
        .tick_i   (tick),
        .len_i    (tail_len),
        .active_o (tail_active)
    );

    // ************
    // Next state
    // ************

    // Synchronisers, speed sampling, boost, motion and calibration.
    always_comb begin
        state_next = state_reg;
        state_next.sync1 = {run_sw_i, jog_rev_i, jog_fwd_i, hole_done_i,
                            manual_hole_i, cut_done_i, cycle_sw_i};
        state_next.sync2 = state_reg.sync1;
        state_next.cycle_q = cycle_s;
        state_next.hole_q  = man_hole_s;
        state_next.tail_q  = tail_active;
        state_next.calc    = 1'b0;

        // Line speed as position counts per tick.
        if (tick) begin
            state_next.tick_cnt = '0;
            state_next.last_pos = position_i;
            state_next.speed    = SPD_W'(position_i - state_reg.last_pos);
        end else begin
            state_next.tick_cnt = state_reg.tick_cnt + TICK_W'(1);
        end

        // Targets arm on load and disarm once fired; a new load wins.
        if (cut_fire) begin
            state_next.cut_armed = 1'b0;
        end
        if (boost_fire) begin
            state_next.boost_armed = 1'b0;
        end
        if (hole_fire) begin
            state_next.hole_armed = 1'b0;
        end
        if (cut_arm_i) begin
            state_next.cut_armed   = 1'b1;
            state_next.boost_armed = 1'b1;
        end
        if (hole_arm_i) begin
            state_next.hole_armed = 1'b1;
        end

        // Boost ends when the tail timer runs out.
        if (state_reg.tail_q && !tail_active) begin
            state_next.boost = 1'b0;
        end
        if (boost_fire) begin
            state_next.boost = 1'b1;
        end

        // Motion: jogging is slow on two-speed lines.
        state_next.fwd  = jog_fwd_s || (run_s && !jog_rev_s);
        state_next.rev  = jog_rev_s && !jog_fwd_s;
        state_next.fast = two_speed_i && fast_req_i && run_s &&
                          !(jog_fwd_s || jog_rev_s);
        state_next.slow = two_speed_i && ((jog_fwd_s || jog_rev_s) ||
                          (run_s && !fast_req_i));

        // Manual calibration parameter stepping.
        if (manual_cal_i && enter_key_i) begin
            state_next.param_idx = (state_reg.param_idx == PARAM_W'(PARAM_COUNT - 1)) ?
                                   '0 : state_reg.param_idx + PARAM_W'(1);
        end else if (manual_cal_i && setup_key_i) begin
            state_next.param_idx = (state_reg.param_idx == '0) ?
                                   PARAM_W'(PARAM_COUNT - 1) :
                                   state_reg.param_idx - PARAM_W'(1);
        end

        // Automatic calibration sequence.
        case (state_reg.cal)
            CAL_IDLE: begin
                if (cal_start_i) begin
                    state_next.cal     = CAL_LEN;
                    state_next.cal_len = CAL_LEN_DEFAULT;
                end
            end
            CAL_LEN: begin
                if (cal_len_valid_i) begin
                    state_next.cal = CAL_TRIM;
                    if (cal_len_i != '0) begin
                        state_next.cal_len = cal_len_i;
                    end
                end
            end
            CAL_TRIM: begin
                if (cut_start) begin
                    state_next.cal = CAL_RUN;
                end
            end
            CAL_RUN: begin
                if (run_s) begin
                    state_next.cal        = CAL_PARTS;
                    state_next.parts_left = two_parts_i;
                end
            end
            CAL_PARTS: begin
                if (cut_start) begin
                    if (state_reg.parts_left) begin
                        state_next.parts_left = 1'b0;
                    end else begin
                        state_next.cal       = CAL_MEAS;
                        state_next.meas_left = two_parts_i;
                    end
                end
            end
            CAL_MEAS: begin
                if (meas_valid_i) begin
                    if (state_reg.meas_left) begin
                        state_next.meas_left = 1'b0;
                    end else begin
                        state_next.cal  = CAL_CALC;
                        state_next.calc = 1'b1;
                    end
                end
            end
            CAL_CALC: begin
                state_next.cal = CAL_IDLE;
            end
            default: begin
                state_next.cal = CAL_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************
    // Outputs
    // ************

    // All outputs come from registers.
    assign cut_o       = cut_active;
    assign hole_o      = hole_active;
    assign boost_o     = state_reg.boost;
    assign fwd_o       = state_reg.fwd;
    assign rev_o       = state_reg.rev;
    assign slow_o      = state_reg.slow;
    assign fast_o      = state_reg.fast;
    assign cal_state_o = state_reg.cal;
    assign cal_len_o   = state_reg.cal_len;
    assign cal_calc_o  = state_reg.calc;
    assign param_idx_o = state_reg.param_idx;

endmodule
`default_nettype wire
